//--- include/cmpdc_pkg.sv
// Package of constants and carriers for the comparator digital control
`default_nettype none
package cmpdc_pkg;
    // Register offsets
    localparam logic [3:0] CTRL0_OFS = 4'h0;
    localparam logic [3:0] CTRL1_OFS = 4'h1;
    localparam logic [3:0] PSEL_OFS = 4'h2;
    localparam logic [3:0] NSEL_OFS = 4'h3;
    localparam logic [3:0] SHOUT_OFS = 4'h4;
    localparam logic [3:0] IRQFLAG_OFS = 4'h5;
    localparam logic [3:0] IRQEN_OFS = 4'h6;
    localparam logic [3:0] IRQCTL_OFS = 4'h7;
    localparam logic [3:0] SHDN_OFS = 4'h8;
    localparam int CMP_STRIDE = 4'h9;
    // Control 0 fields
    localparam int ENABLE_BIT = 7;
    localparam int OUTPUT_BIT = 6;
    localparam int INVERT_BIT = 4;
    localparam int HYST_BIT = 1;
    localparam int SYNC_BIT = 0;
    // Control 1 fields
    localparam int RISE_BIT = 1;
    localparam int FALL_BIT = 0;
    // Irq control fields
    localparam int GIE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
    // Channel codes
    localparam logic [2:0] PCH_PIN = 3'h0;
    localparam logic [2:0] PCH_DAC = 3'h1;
    localparam logic [2:0] PCH_FREF = 3'h2;
    localparam logic [2:0] PCH_GND = 3'h3;
    localparam logic [2:0] NCH_PIN = 3'h0;
    localparam logic [2:0] NCH_FREF = 3'h1;
    localparam logic [2:0] NCH_GND = 3'h2;
    localparam logic [7:0] RESET_VAL = 8'h00;

    typedef struct packed {
        logic enable;
        logic invert;
        logic hyst;
        logic sync;
        logic riseEn;
        logic fallEn;
        logic irqEn;
        logic shdnEn;
        logic [2:0] posSel;
        logic [2:0] negSel;
    } cmpdc_ctrl_s;

    typedef struct packed {
        logic [1:0] syncPipe;
        logic latched;
        logic syncLatched;
        logic outPrev;
        logic flag;
    } cmpdc_chan_s;
endpackage : cmpdc_pkg
`default_nettype wire

//--- src/cmpdc_top.sv
// Comparator digital control: registers, latching, edges and exports
`timescale 1ns/10ps
`default_nettype none
module cmpdc_top #(
    parameter int NUM_CMP = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    // Analog side
    input wire logic [NUM_CMP-1:0] cmpRaw,
    output logic [NUM_CMP-1:0] anaPowerOn,
    output logic [NUM_CMP*3-1:0] posChanSel,
    output logic [NUM_CMP*3-1:0] negChanSel,
    output logic [NUM_CMP-1:0] hystOn,
    // Timer1 side
    input wire logic timerClkPre,
    input wire logic sleepMode,
    input wire logic timerOnCoreClk,
    output logic [NUM_CMP-1:0] timerGateSrc,
    // Pin, waveform generator, processor
    output logic [NUM_CMP-1:0] pinOutSrc,
    output logic [NUM_CMP-1:0] wgShutdown,
    output logic irqReq,
    output logic wakeReq
);
    // Instance count check
    if (NUM_CMP < 1 || NUM_CMP > 2) begin : g_badCount
        $error("NUM_CMP must be 1 or 2");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        cmpdc_pkg::cmpdc_ctrl_s [1:0] ctrl;
        cmpdc_pkg::cmpdc_chan_s [1:0] chan;
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic tmrPrev;
        logic [7:0] rdData;
        logic [1:0] pwr;
        logic [5:0] psel;
        logic [5:0] nsel;
        logic [1:0] hysO;
        logic [1:0] gate;
        logic [1:0] pin;
        logic [1:0] shdn;
        logic irq;
        logic wake;
    } cmpdc_state_s;

    cmpdc_state_s state_reg;
    cmpdc_state_s state_next;

    function automatic logic [7:0] readReg(input cmpdc_state_s s,
                                           input logic [7:0] a);
        logic [7:0] d;
        int i;
        d = 8'h00;
        for (i = 0; i < NUM_CMP; i++) begin
            if (a == 8'(i * cmpdc_pkg::CMP_STRIDE + cmpdc_pkg::CTRL0_OFS)) begin
                d[cmpdc_pkg::ENABLE_BIT] = s.ctrl[i].enable;
                d[cmpdc_pkg::OUTPUT_BIT] = s.chan[i].outPrev;
                d[cmpdc_pkg::INVERT_BIT] = s.ctrl[i].invert;
                d[cmpdc_pkg::HYST_BIT] = s.ctrl[i].hyst;
                d[cmpdc_pkg::SYNC_BIT] = s.ctrl[i].sync;
            end
            if (a == 8'(i * cmpdc_pkg::CMP_STRIDE + cmpdc_pkg::CTRL1_OFS)) begin
                d[cmpdc_pkg::RISE_BIT] = s.ctrl[i].riseEn;
                d[cmpdc_pkg::FALL_BIT] = s.ctrl[i].fallEn;
            end
            if (a == 8'(i * cmpdc_pkg::CMP_STRIDE + cmpdc_pkg::PSEL_OFS)) begin
                d[2:0] = s.ctrl[i].posSel;
            end
            if (a == 8'(i * cmpdc_pkg::CMP_STRIDE + cmpdc_pkg::NSEL_OFS)) begin
                d[2:0] = s.ctrl[i].negSel;
            end
            if (a == 8'(i * cmpdc_pkg::CMP_STRIDE + cmpdc_pkg::SHDN_OFS)) begin
                d[0] = s.ctrl[i].shdnEn;
            end
            if (a == 8'(cmpdc_pkg::SHOUT_OFS)) begin
                d[i] = s.chan[i].outPrev;
            end
            if (a == 8'(cmpdc_pkg::IRQFLAG_OFS)) begin
                d[i] = s.chan[i].flag;
            end
            if (a == 8'(cmpdc_pkg::IRQEN_OFS)) begin
                d[i] = s.ctrl[i].irqEn;
            end
        end
        if (a == 8'(cmpdc_pkg::IRQCTL_OFS)) begin
            d[cmpdc_pkg::GIE_BIT] = s.global_irq_enable;
            d[cmpdc_pkg::PERIPHERAL_IRQ_ENABLE_BIT] = s.peripheral_irq_enable;
        end
        return d;
    endfunction : readReg

    function automatic logic hitReg(input logic [7:0] a, input int i,
                                    input logic [3:0] ofs);
        return a == 8'(i * cmpdc_pkg::CMP_STRIDE + ofs);
    endfunction : hitReg

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic shownOut;
        logic rise;
        logic fall;
        logic tmrFall;
        logic anyIrq;
        int i;
        shownOut = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        anyIrq = 1'b0;
        i = 0;
        state_next = state_reg;
        tmrFall = state_reg.tmrPrev & ~timerClkPre;
        state_next.tmrPrev = timerClkPre;
        state_next.rdData = regRead ? readReg(state_reg, regAddr) : 8'h00;
        if (regWrite && regAddr == 8'(cmpdc_pkg::IRQCTL_OFS)) begin
            state_next.global_irq_enable = regWrData[cmpdc_pkg::GIE_BIT];
            state_next.peripheral_irq_enable = regWrData[cmpdc_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
        end
        for (i = 0; i < NUM_CMP; i++) begin
            if (regWrite && hitReg(regAddr, i, cmpdc_pkg::CTRL0_OFS)) begin
                state_next.ctrl[i].enable = regWrData[cmpdc_pkg::ENABLE_BIT];
                state_next.ctrl[i].invert = regWrData[cmpdc_pkg::INVERT_BIT];
                state_next.ctrl[i].hyst = regWrData[cmpdc_pkg::HYST_BIT];
                state_next.ctrl[i].sync = regWrData[cmpdc_pkg::SYNC_BIT];
            end
            if (regWrite && hitReg(regAddr, i, cmpdc_pkg::CTRL1_OFS)) begin
                state_next.ctrl[i].riseEn = regWrData[cmpdc_pkg::RISE_BIT];
                state_next.ctrl[i].fallEn = regWrData[cmpdc_pkg::FALL_BIT];
            end
            if (regWrite && hitReg(regAddr, i, cmpdc_pkg::PSEL_OFS)) begin
                state_next.ctrl[i].posSel = regWrData[2:0];
            end
            if (regWrite && hitReg(regAddr, i, cmpdc_pkg::NSEL_OFS)) begin
                state_next.ctrl[i].negSel = regWrData[2:0];
            end
            if (regWrite && hitReg(regAddr, i, cmpdc_pkg::SHDN_OFS)) begin
                state_next.ctrl[i].shdnEn = regWrData[0];
            end
            if (regWrite && regAddr == 8'(cmpdc_pkg::IRQEN_OFS)) begin
                state_next.ctrl[i].irqEn = regWrData[i];
            end
            // Synchroniser then per-cycle latch
            state_next.chan[i].syncPipe = {state_reg.chan[i].syncPipe[0],
                                           cmpRaw[i]};
            // Raw high when positive exceeds negative; gated and inverted
            state_next.chan[i].latched = (state_reg.chan[i].syncPipe[1]
                & state_reg.ctrl[i].enable)
                ^ state_reg.ctrl[i].invert;
            if (tmrFall && !(sleepMode && timerOnCoreClk)) begin
                state_next.chan[i].syncLatched =
                    state_reg.chan[i].latched;
            end
            shownOut = state_reg.ctrl[i].sync ?
                state_reg.chan[i].syncLatched : state_reg.chan[i].latched;
            state_next.chan[i].outPrev = shownOut;
            rise = shownOut & ~state_reg.chan[i].outPrev;
            fall = ~shownOut & state_reg.chan[i].outPrev;
            if (regWrite && regAddr == 8'(cmpdc_pkg::IRQFLAG_OFS)) begin
                state_next.chan[i].flag = regWrData[i];
            end
            if ((rise && state_reg.ctrl[i].riseEn)
                || (fall && state_reg.ctrl[i].fallEn)) begin
                state_next.chan[i].flag = 1'b1;
            end
            if (state_next.chan[i].flag && state_next.ctrl[i].irqEn) begin
                anyIrq = 1'b1;
            end
            state_next.pwr[i] = state_next.ctrl[i].enable;
            state_next.psel[i*3 +: 3] = state_next.ctrl[i].enable ?
                state_next.ctrl[i].posSel : cmpdc_pkg::PCH_GND;
            state_next.nsel[i*3 +: 3] = state_next.ctrl[i].enable ?
                state_next.ctrl[i].negSel : cmpdc_pkg::NCH_GND;
            state_next.hysO[i] = state_next.ctrl[i].hyst
                & state_next.ctrl[i].enable;
            state_next.gate[i] = shownOut;
            state_next.pin[i] = shownOut;
            state_next.shdn[i] = shownOut & state_reg.ctrl[i].shdnEn;
        end
        state_next.irq = anyIrq & state_next.global_irq_enable & state_next.peripheral_irq_enable;
        state_next.wake = anyIrq;
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
            state_reg.psel <= {2{cmpdc_pkg::PCH_GND}};
            state_reg.nsel <= {2{cmpdc_pkg::NCH_GND}};
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign regRdData = state_reg.rdData;
    assign anaPowerOn = state_reg.pwr[NUM_CMP-1:0];
    assign posChanSel = state_reg.psel[NUM_CMP*3-1:0];
    assign negChanSel = state_reg.nsel[NUM_CMP*3-1:0];
    assign hystOn = state_reg.hysO[NUM_CMP-1:0];
    assign timerGateSrc = state_reg.gate[NUM_CMP-1:0];
    assign pinOutSrc = state_reg.pin[NUM_CMP-1:0];
    assign wgShutdown = state_reg.shdn[NUM_CMP-1:0];
    assign irqReq = state_reg.irq;
    assign wakeReq = state_reg.wake;
endmodule : cmpdc_top
`default_nettype wire

//--- testbench/cmpdc_chk.sv
// Assertion checker for the comparator digital control
`timescale 1ns/10ps
`default_nettype none
module cmpdc_chk #(
    parameter int NUM_CMP = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    // Analog and export side
    input wire logic [NUM_CMP-1:0] anaPowerOn,
    input wire logic [NUM_CMP*3-1:0] posChanSel,
    input wire logic [NUM_CMP*3-1:0] negChanSel,
    input wire logic [NUM_CMP-1:0] hystOn,
    input wire logic [NUM_CMP-1:0] timerGateSrc,
    input wire logic [NUM_CMP-1:0] pinOutSrc,
    input wire logic [NUM_CMP-1:0] wgShutdown,
    input wire logic irqReq,
    input wire logic wakeReq
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    property p_pwr;
        regWrite && regAddr == 8'h00 && regWrData[7] |-> ##1 anaPowerOn[0];
    endproperty
    a_pwr: assert property (p_pwr)
        else $error("power not on");
    property p_pwrOff;
        regWrite && regAddr == 8'h00 && !regWrData[7] |-> ##1 !anaPowerOn[0];
    endproperty
    a_pwrOff: assert property (p_pwrOff)
        else $error("power not off");
    property p_gnd;
        !anaPowerOn[0] |-> posChanSel[2:0] == cmpdc_pkg::PCH_GND
            && negChanSel[2:0] == cmpdc_pkg::NCH_GND;
    endproperty
    a_gnd: assert property (p_gnd)
        else $error("inputs not released");
    property p_hys;
        hystOn[0] |-> anaPowerOn[0];
    endproperty
    a_hys: assert property (p_hys)
        else $error("hysteresis while off");
    property p_gate;
        timerGateSrc == pinOutSrc;
    endproperty
    a_gate: assert property (p_gate)
        else $error("gate source differs");
    property p_shdn;
        wgShutdown[0] |-> pinOutSrc[0];
    endproperty
    a_shdn: assert property (p_shdn)
        else $error("shutdown without output");
    property p_wake;
        irqReq |-> wakeReq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("irq without enabled flag");
    property p_gie;
        regWrite && regAddr == 8'h07 && !regWrData[7] |-> ##1 !irqReq;
    endproperty
    a_gie: assert property (p_gie)
        else $error("irq despite global mask");
    property p_rd;
        !$past(regRead) |-> regRdData == 8'h00;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read data outside slot");
    c_irq: cover property (irqReq);
    c_shdn: cover property (wgShutdown[0]);
    c_out: cover property ($rose(pinOutSrc[0]));
    c_wake: cover property (wakeReq && !irqReq);
endmodule : cmpdc_chk
bind cmpdc_top cmpdc_chk #(.NUM_CMP(NUM_CMP)) u_chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdData(regRdData),
    .anaPowerOn(anaPowerOn),
    .posChanSel(posChanSel),
    .negChanSel(negChanSel),
    .hystOn(hystOn),
    .timerGateSrc(timerGateSrc),
    .pinOutSrc(pinOutSrc),
    .wgShutdown(wgShutdown),
    .irqReq(irqReq),
    .wakeReq(wakeReq)
);
`default_nettype wire

//--- testbench/cmpdc_model.sv
// Model of the analog sources and the prescaled timer clock
`timescale 1ns/10ps
`default_nettype none
module cmpdc_model #(
    parameter int PRE = 4
) (
    // Clock
    input wire logic core_clk,
    // Analog levels
    input wire logic [1:0][7:0] posLvl,
    input wire logic [1:0][7:0] negLvl,
    // Digital view
    output logic [1:0] cmpRaw,
    output logic timerClkPre
);
    int cnt = 0;
    logic clkDiv = 1'b0;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cmpRaw[i] = posLvl[i] > negLvl[i];
        end
    end
    always @(posedge core_clk) begin
        cnt <= (cnt + 1) % PRE;
        if (cnt == PRE - 1) begin
            clkDiv <= ~clkDiv;
        end
    end
    assign timerClkPre = clkDiv;
endmodule : cmpdc_model
`default_nettype wire

//--- testbench/cmpdc_tb.sv
// Self-checking bench for the comparator digital control
`timescale 1ns/10ps
`default_nettype none
module cmpdc_tb;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic sleepMode = 1'b0;
    logic timerOnCoreClk = 1'b0;
    logic [1:0][7:0] posLvl = 16'h0000;
    logic [1:0][7:0] negLvl = 16'h0000;
    logic [1:0] cmpRaw, anaPowerOn, hystOn, timerGateSrc, pinOutSrc, wgShutdown;
    logic [5:0] posChanSel, negChanSel;
    logic [7:0] regRdData;
    logic timerClkPre, irqReq, wakeReq;
    int errTotal = 0;
    int checkCount = 0;
    int cycles = 0;
    cmpdc_model u_model (
        .core_clk(core_clk),
        .posLvl(posLvl),
        .negLvl(negLvl),
        .cmpRaw(cmpRaw),
        .timerClkPre(timerClkPre)
    );
    cmpdc_top #(.NUM_CMP(2)) u_dut (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdData(regRdData),
        .cmpRaw(cmpRaw),
        .anaPowerOn(anaPowerOn),
        .posChanSel(posChanSel),
        .negChanSel(negChanSel),
        .hystOn(hystOn),
        .timerClkPre(timerClkPre),
        .sleepMode(sleepMode),
        .timerOnCoreClk(timerOnCoreClk),
        .timerGateSrc(timerGateSrc),
        .pinOutSrc(pinOutSrc),
        .wgShutdown(wgShutdown),
        .irqReq(irqReq),
        .wakeReq(wakeReq)
    );
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errTotal = errTotal + 1;
            completeRun();
        end
    end
    // ****************
    // Tasks
    // ****************
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checkCount++;
        if (g !== e) begin
            errTotal++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, regRdData);
    endtask : rd
    task automatic lv(input logic [7:0] p, input logic [7:0] n);
        @(posedge core_clk);
        posLvl[0] <= p;
        negLvl[0] <= n;
    endtask : lv
    task automatic completeRun();
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : completeRun
    // ****************
    // Tests
    // ****************
    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 9; a++) begin
            rd(a[7:0], 8'h00);
        end
        rd(8'h30, 8'h00);
        chk("pos reset", 8'h03, {5'h00, posChanSel[2:0]});
        lv(8'h80, 8'h40);
        wr(8'h00, 8'h80);
        wt(8);
        rd(8'h00, 8'hC0);
        rd(8'h04, 8'h01);
        chk("pin", 8'h01, {7'h00, pinOutSrc[0]});
        chk("gate", 8'h01, {7'h00, timerGateSrc[0]});
        chk("power on", 8'h01, {7'h00, anaPowerOn[0]});
        wr(8'h08, 8'h01);
        wt(3);
        chk("shutdown", 8'h01, {7'h00, wgShutdown[0]});
        wr(8'h00, 8'h92);
        wt(8);
        rd(8'h00, 8'h92);
        chk("hyst", 8'h01, {7'h00, hystOn[0]});
        chk("shutdown low", 8'h00, {7'h00, wgShutdown[0]});
        for (int c = 0; c < 4; c++) begin
            wr(8'h02, c[7:0]);
            wr(8'h03, (c > 2) ? 8'h02 : c[7:0]);
            wt(2);
            chk("pos", c[7:0], {5'h00, posChanSel[2:0]});
            chk("neg", (c > 2) ? 8'h02 : c[7:0], {5'h00, negChanSel[2:0]});
        end
        wr(8'h02, 8'h01);
        wr(8'h03, 8'h01);
        rd(8'h02, 8'h01);
        wr(8'h00, 8'h00);
        wt(3);
        chk("pos off", 8'h03, {5'h00, posChanSel[2:0]});
        chk("neg off", 8'h02, {5'h00, negChanSel[2:0]});
        chk("power off", 8'h00, {6'h00, anaPowerOn});
        chk("hyst off", 8'h00, {7'h00, hystOn[0]});
        wr(8'h01, 8'h02);
        wr(8'h06, 8'h01);
        wr(8'h07, 8'hC0);
        wr(8'h00, 8'h10);
        wt(8);
        rd(8'h05, 8'h01);
        chk("irq", 8'h01, {7'h00, irqReq});
        wr(8'h07, 8'h40);
        wt(2);
        chk("irq masked", 8'h00, {7'h00, irqReq});
        chk("wake", 8'h01, {7'h00, wakeReq});
        wr(8'h07, 8'hC0);
        wr(8'h05, 8'h00);
        rd(8'h05, 8'h00);
        chk("wake off", 8'h00, {7'h00, wakeReq});
        wr(8'h00, 8'h00);
        wr(8'h00, 8'h10);
        wr(8'h05, 8'h00);
        rd(8'h05, 8'h01);
        wr(8'h05, 8'h00);
        wr(8'h01, 8'h01);
        wr(8'h00, 8'h00);
        wt(8);
        rd(8'h05, 8'h01);
        wr(8'h05, 8'h00);
        wr(8'h00, 8'h10);
        wt(8);
        rd(8'h05, 8'h00);
        wr(8'h00, 8'h81);
        wt(20);
        chk("sync high", 8'h01, {7'h00, pinOutSrc[0]});
        @(posedge core_clk);
        sleepMode <= 1'b1;
        timerOnCoreClk <= 1'b1;
        lv(8'h10, 8'h40);
        wt(20);
        chk("frozen", 8'h01, {7'h00, pinOutSrc[0]});
        @(posedge core_clk);
        sleepMode <= 1'b0;
        wt(20);
        chk("synced", 8'h00, {7'h00, pinOutSrc[0]});
        wr(8'h09, 8'h80);
        wt(3);
        chk("power", 8'h03, {6'h00, anaPowerOn});
        rd(8'h09, 8'h80);
        completeRun();
    end
endmodule : cmpdc_tb
`default_nettype wire
